// ### core/urxe_pkg.sv
// Shared constants for the receive error status block
package urxe_pkg;

    // Register byte offsets
    localparam logic [7:0] URXE_OFS_DATA = 8'h00;
    localparam logic [7:0] URXE_OFS_LSR  = 8'h04;
    localparam logic [7:0] URXE_OFS_CTRL = 8'h08;
    localparam logic [7:0] URXE_OFS_IST  = 8'h0C;
    localparam logic [7:0] URXE_OFS_MASK = 8'h10;
    localparam logic [7:0] URXE_OFS_DIV  = 8'h14;

    // Line status fields
    localparam int URXE_LSR_AVAIL = 0;
    localparam int URXE_LSR_OVR   = 1;
    localparam int URXE_LSR_PAR   = 2;

    // Control fields
    localparam int URXE_CTL_FIFO = 0;
    localparam int URXE_CTL_EVEN = 1;
    localparam int URXE_CTL_PEN  = 2;

    // Interrupt status and mask share the line status layout
    localparam int URXE_EVT_W = 3;

    // Reset values
    localparam logic [2:0]  URXE_CTRL_RST = 3'h0;
    localparam logic [2:0]  URXE_MASK_RST = 3'h0;
    localparam logic [15:0] URXE_DIV_RST  = 16'h0035;

    // Character format, oversampling and FIFO depth
    localparam int         URXE_CHAR_W    = 8;
    localparam logic [3:0] URXE_OVS_MID   = 4'h7;
    localparam logic [3:0] URXE_OVS_LAST  = 4'hF;
    localparam int         URXE_FIFO_DEPTH = 16;

endpackage : urxe_pkg

// ### core/urxe_fifo.sv
// Receive FIFO holding each character with its error tag
`timescale 1ns/1ps
`default_nettype none
module urxe_fifo
    import urxe_pkg::*;
#(
    parameter int WIDTH = URXE_CHAR_W + 1,
    parameter int DEPTH = URXE_FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Control
    input  wire logic             push_i,
    input  wire logic             pop_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Status
    output logic      [WIDTH-1:0] head_o,
    output logic                  empty_o,
    output logic                  full_o
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
        begin : g_bad
            $error("urxe_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } urxe_fifo_st_t;

    urxe_fifo_st_t    q;
    urxe_fifo_st_t    next_q;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             do_push;
    logic             do_pop;

    assign do_push = push_i && !full_o && !flush_i;
    assign do_pop  = pop_i && !empty_o && !flush_i;
    assign head_o  = mem[q.rd];
    assign empty_o = (q.cnt == '0);
    assign full_o  = (q.cnt == (AW+1)'(DEPTH));

    always_comb
    begin
        next_q = q;
        if (flush_i)
        begin
            next_q = '0;
        end
        else
        begin
            if (do_push)
            begin
                next_q.wr = q.wr + 1'b1;
            end
            if (do_pop)
            begin
                next_q.rd = q.rd + 1'b1;
            end
            next_q.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    // Storage carries no reset; contents are only read behind the count
    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem[q.wr] <= wdata_i;
        end
    end

endmodule // urxe_fifo
`default_nettype wire

// ### core/urxe_rx_deser.sv
// Serial deserialiser with 16x oversampling and parity check
`timescale 1ns/1ps
`default_nettype none
module urxe_rx_deser
    import urxe_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    // Line and format
    input  wire logic                   tick_i,
    input  wire logic                   rxd_i,
    input  wire logic                   par_en_i,
    input  wire logic                   even_i,
    // Received character
    output logic                        done_o,
    output logic [URXE_CHAR_W-1:0]      data_o,
    output logic                        perr_o
);
    typedef enum logic [2:0] {
        URXE_IDLE  = 3'b000,
        URXE_START = 3'b001,
        URXE_DATA  = 3'b010,
        URXE_PAR   = 3'b011,
        URXE_STOP  = 3'b100
    } urxe_rx_state_t;

    typedef struct packed {
        urxe_rx_state_t         st;
        logic [3:0]             ovs;
        logic [2:0]             bitn;
        logic [URXE_CHAR_W-1:0] sh;
        logic                   par;
        logic                   done;
        logic                   perr;
    } urxe_rx_st_t;

    urxe_rx_st_t q;
    urxe_rx_st_t next_q;

    assign done_o = q.done;
    assign data_o = q.sh;
    assign perr_o = q.perr;

    always_comb
    begin
        next_q      = q;
        next_q.done = 1'b0;
        if (tick_i)
        begin
            next_q.ovs = q.ovs + 1'b1;
            unique case (q.st)
                URXE_IDLE:
                begin
                    next_q.ovs = '0;
                    if (!rxd_i)
                    begin
                        next_q.st = URXE_START;
                    end
                end
                URXE_START:
                    if (q.ovs == URXE_OVS_MID)
                    begin
                        next_q.ovs  = '0;
                        next_q.bitn = '0;
                        next_q.st   = rxd_i ? URXE_IDLE : URXE_DATA;
                    end
                URXE_DATA:
                    if (q.ovs == URXE_OVS_LAST)
                    begin
                        next_q.sh   = {rxd_i, q.sh[URXE_CHAR_W-1:1]};
                        next_q.bitn = q.bitn + 1'b1;
                        if (q.bitn == 3'(URXE_CHAR_W - 1))
                        begin
                            next_q.st = par_en_i ? URXE_PAR : URXE_STOP;
                        end
                    end
                URXE_PAR:
                    if (q.ovs == URXE_OVS_LAST)
                    begin
                        next_q.par = rxd_i;
                        next_q.st  = URXE_STOP;
                    end
                URXE_STOP:
                    // R1 check during stop bit
                    if (q.ovs == URXE_OVS_LAST)
                    begin
                        next_q.done = 1'b1;
                        next_q.perr = par_en_i && ((^{q.sh, q.par}) == even_i);
                        next_q.st   = URXE_IDLE;
                    end
                default:
                    next_q.st = URXE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule // urxe_rx_deser
`default_nettype wire

// ### core/urxe_top.sv
// Receive channel with parity and overrun status behind Wishbone
//
// Summary of operation
// R1 - Parity fault flag set at stop bit when received parity mismatches.
// R2 - Non-FIFO: parity fault clears on line status read or next valid character.
// R3 - FIFO mode: parity fault shown only when its character is at head.
// R4 - Non-FIFO: unread holding character overwritten by new one, overrun flagged.
// R5 - Overrun flag clears whenever line status register is read.
// R6 - FIFO mode: overrun only when FIFO full and another character completes.
// R7 - FIFO overrun: FIFO untouched, shift character dropped and overwritable.
// R8 - Overrun shown at once, not tied to FIFO head.
// R9 - Overrun flag set at stop bit of the offending character.
// R10 - Parity and overrun flags are zero after reset.
// R11 - Data available set on stored character, cleared when all read.
// R12 - FIFO entries carry the parity tag beside the character.
`timescale 1ns/1ps
`default_nettype none
module urxe_top
    import urxe_pkg::*;
#(
    parameter int FIFO_DEPTH = URXE_FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial line
    input  wire logic        rx_serial_i,
    // Interrupt
    output logic             irq_o
);
    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("urxe_top: FIFO_DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic                   ack;
        logic [31:0]            dat;
        logic                   irq;
        logic [URXE_CHAR_W-1:0] hold_data;
        logic                   hold_full;
        logic                   pe_flag;
        logic                   ovr;
        logic [2:0]             ctrl;
        logic [URXE_EVT_W-1:0]  mask;
        logic [URXE_EVT_W-1:0]  ist;
        logic [15:0]            div;
        logic [15:0]            divcnt;
        logic                   tick;
    } urxe_top_st_t;

    urxe_top_st_t           q;
    urxe_top_st_t           next_q;

    logic                   rx_done;
    logic [URXE_CHAR_W-1:0] rx_data;
    logic                   rx_perr;
    logic [URXE_CHAR_W:0]   fifo_head;
    logic                   fifo_empty;
    logic                   fifo_full;
    logic                   fifo_push;
    logic                   fifo_pop;
    logic                   fifo_flush;
    logic                   take;
    logic                   rd;
    logic                   wr;
    logic                   fifo_mode;
    logic [7:0]             lsr;
    logic [URXE_CHAR_W:0]   rx_word;
    logic                   lsr_rd;
    logic                   data_rd;
    logic                   ist_rd;
    logic                   ctrl_wr;

    assign wb_ack_o  = q.ack;
    assign wb_dat_o  = q.dat;
    assign irq_o     = q.irq;
    assign fifo_mode = q.ctrl[URXE_CTL_FIFO];

    // Low ack gates take: one answer per request
    assign take = wb_cyc_i && wb_stb_i && !q.ack;
    assign rd   = take && !wb_we_i;
    assign wr   = take && wb_we_i;

    // Register strobes, one per side effect
    assign lsr_rd  = rd && (wb_adr_i == URXE_OFS_LSR);
    assign data_rd = rd && (wb_adr_i == URXE_OFS_DATA);
    assign ist_rd  = rd && (wb_adr_i == URXE_OFS_IST);
    assign ctrl_wr = wr && (wb_adr_i == URXE_OFS_CTRL) && wb_sel_i[0];

    // R7 full FIFO refuses the new character
    assign fifo_push = rx_done && fifo_mode && !fifo_full;
    assign fifo_pop  = data_rd && fifo_mode;
    // Mode change empties both stores so no stale tag survives
    assign fifo_flush = ctrl_wr && (wb_dat_i[URXE_CTL_FIFO] != fifo_mode);

    always_comb
    begin
        lsr = 8'h00;
        // R8 overrun flag is independent of FIFO head
        lsr[URXE_LSR_OVR] = q.ovr;
        if (fifo_mode)
        begin
            // R11 available while anything unread
            lsr[URXE_LSR_AVAIL] = !fifo_empty;
            // R3 parity tag of head character only
            lsr[URXE_LSR_PAR]   = !fifo_empty && fifo_head[URXE_CHAR_W];
        end
        else
        begin
            // R11 holding register unread
            lsr[URXE_LSR_AVAIL] = q.hold_full;
            // R2 flag of the last character
            lsr[URXE_LSR_PAR]   = q.pe_flag;
        end
    end

    // Empty FIFO reads zero, its storage has no reset
    always_comb
    begin
        if (!fifo_mode)
        begin
            rx_word = {1'b0, q.hold_data};
        end
        else if (fifo_empty)
        begin
            rx_word = '0;
        end
        else
        begin
            rx_word = fifo_head;
        end
    end

    urxe_rx_deser u_deser (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (q.tick),
        .rxd_i     (rx_serial_i),
        .par_en_i  (q.ctrl[URXE_CTL_PEN]),
        .even_i    (q.ctrl[URXE_CTL_EVEN]),
        .done_o    (rx_done),
        .data_o    (rx_data),
        .perr_o    (rx_perr)
    );

    // R12 tag travels in the same entry
    urxe_fifo #(
        .WIDTH (URXE_CHAR_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .push_i    (fifo_push),
        .pop_i     (fifo_pop),
        .flush_i   (fifo_flush),
        .wdata_i   ({rx_perr, rx_data}),
        .head_o    (fifo_head),
        .empty_o   (fifo_empty),
        .full_o    (fifo_full)
    );

    always_comb
    begin
        next_q      = q;
        next_q.tick = 1'b0;
        next_q.ack  = take;

        // 16x sample rate enable
        // Free-running; the receiver realigns on each start edge
        if (q.divcnt >= q.div)
        begin
            next_q.divcnt = '0;
            next_q.tick   = 1'b1;
        end
        else
        begin
            next_q.divcnt = q.divcnt + 1'b1;
        end

        // Read data, unmapped offsets answer zero
        if (rd)
        begin
            unique case (wb_adr_i)
                URXE_OFS_DATA:
                begin
                    next_q.dat = {23'h00_0000, rx_word};
                end
                URXE_OFS_LSR:
                begin
                    next_q.dat = {24'h00_0000, lsr};
                end
                URXE_OFS_CTRL:
                begin
                    next_q.dat = {29'h0000_0000, q.ctrl};
                end
                URXE_OFS_IST:
                begin
                    next_q.dat = {29'h0000_0000, q.ist};
                end
                URXE_OFS_MASK:
                begin
                    next_q.dat = {29'h0000_0000, q.mask};
                end
                URXE_OFS_DIV:
                begin
                    next_q.dat = {16'h0000, q.div};
                end
                default:
                begin
                    next_q.dat = 32'h0000_0000;
                end
            endcase
        end

        // Writes, per byte lane
        if (wr)
        begin
            if (wb_adr_i == URXE_OFS_CTRL && wb_sel_i[0])
            begin
                next_q.ctrl = wb_dat_i[2:0];
            end
            if (wb_adr_i == URXE_OFS_MASK && wb_sel_i[0])
            begin
                next_q.mask = wb_dat_i[URXE_EVT_W-1:0];
            end
            if (wb_adr_i == URXE_OFS_DIV)
            begin
                if (wb_sel_i[0])
                begin
                    next_q.div[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1])
                begin
                    next_q.div[15:8] = wb_dat_i[15:8];
                end
            end
        end
        // Flush also drops the non-FIFO character and its flag
        if (fifo_flush)
        begin
            next_q.hold_full = 1'b0;
            next_q.pe_flag   = 1'b0;
        end

        // Clears first so a same-cycle event wins
        if (lsr_rd)
        begin
            // R5 overrun cleared by status read
            next_q.ovr = 1'b0;
            // R2 parity cleared by status read
            next_q.pe_flag = 1'b0;
        end
        if (data_rd && !fifo_mode)
        begin
            // R11 holding register consumed
            next_q.hold_full = 1'b0;
        end
        // Event register read clears every bit
        if (ist_rd)
        begin
            next_q.ist = '0;
        end

        if (rx_done && !fifo_flush)
        begin
            if (fifo_mode)
            begin
                // R6 overrun only on a full FIFO
                if (fifo_full)
                begin
                    // R7 character dropped, FIFO untouched
                    // R9 set at stop bit
                    next_q.ovr = 1'b1;
                    next_q.ist[URXE_LSR_OVR] = 1'b1;
                end
                else
                begin
                    next_q.ist[URXE_LSR_AVAIL] = 1'b1;
                    if (rx_perr)
                    begin
                        next_q.ist[URXE_LSR_PAR] = 1'b1;
                    end
                end
            end
            else
            begin
                // R4 overwrite and flag if unread
                if (q.hold_full && !data_rd)
                begin
                    // R9 set at stop bit
                    next_q.ovr = 1'b1;
                    next_q.ist[URXE_LSR_OVR] = 1'b1;
                end
                next_q.hold_data = rx_data;
                next_q.hold_full = 1'b1;
                // R1 flag follows the new character
                // R2 a clean character clears it
                next_q.pe_flag = rx_perr;
                next_q.ist[URXE_LSR_AVAIL] = 1'b1;
                if (rx_perr)
                begin
                    next_q.ist[URXE_LSR_PAR] = 1'b1;
                end
            end
        end

        // Level output from the status and mask being registered
        next_q.irq = |(next_q.ist & next_q.mask);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            // R10 flags start clear
            q.ack       <= 1'b0;
            q.dat       <= 32'h0000_0000;
            q.irq       <= 1'b0;
            q.hold_data <= '0;
            q.hold_full <= 1'b0;
            q.pe_flag   <= 1'b0;
            q.ovr       <= 1'b0;
            q.ctrl      <= URXE_CTRL_RST;
            q.mask      <= URXE_MASK_RST;
            q.ist       <= '0;
            q.div       <= URXE_DIV_RST;
            q.divcnt    <= '0;
            q.tick      <= 1'b0;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule // urxe_top
`default_nettype wire

// ### test/urxe_top_assertions.sv
// Bus and interrupt checker bound to the receive status top
`timescale 1ns/1ps
`default_nettype none
module urxe_top_assertions
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Serial line and interrupt
    input wire logic        rx_serial_i,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rst_quiet;
        $fell(sys_rst_i) |-> !irq_o && !wb_ack_o && wb_dat_o == 32'h0000_0000;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
    property p_dat_hold;
        !(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) |=> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data changed without read");
    property p_unmapped;
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h18)
            |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_upper_zero; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    // Status only clears through a bus access
    property p_irq_fall; $fell(irq_o) |-> $past(wb_cyc_i, 1) || $past(wb_cyc_i, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without access");
endmodule // urxe_top_assertions

bind urxe_top urxe_top_assertions urxe_top_assertions_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_serial_i(rx_serial_i), .irq_o(irq_o));
`default_nettype wire

// ### test/urxe_tx_model.sv
// Remote serial transmitter: start, 8 data LSB first, parity, stop
`timescale 1ns/1ps
`default_nettype none
module urxe_tx_model
#(
    parameter int BIT_CLKS = 16
)
(
    // Clock
    input  wire logic       clk_i,
    // Character and parity bit to send
    input  wire logic       send_i,
    input  wire logic [7:0] char_i,
    input  wire logic       par_i,
    // Serial line and activity
    output var logic        line_o,
    output var logic        busy_o
);
    logic [10:0] frame;
    int          nbit;
    int          ncyc;
    initial
    begin
        line_o = 1'b1;
        busy_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        if (!busy_o && send_i)
        begin
            frame  <= {1'b1, par_i, char_i, 1'b0};
            line_o <= 1'b0;
            busy_o <= 1'b1;
            nbit   <= 0;
            ncyc   <= 0;
        end
        else if (busy_o && ncyc == BIT_CLKS - 1)
        begin
            ncyc   <= 0;
            nbit   <= nbit + 1;
            busy_o <= (nbit != 10);
            line_o <= (nbit == 10) ? 1'b1 : frame[nbit+1];
        end
        else if (busy_o)
            ncyc <= ncyc + 1;
    end
endmodule // urxe_tx_model
`default_nettype wire

// ### test/tb_uart_rx_error_status.sv
// Register-level bench for the receive error status block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_rx_error_status;
    import urxe_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic        line;
    logic        busy;
    logic        send = 1'b0;
    logic [7:0]  tx_char = 8'h00;
    logic        tx_par = 1'b0;
    logic        odd = 1'b0;
    logic [31:0] v;
    int          n_fail = 0;
    int          checked = 0;

    always #5 clk_i = ~clk_i;

    urxe_top #(.FIFO_DEPTH(4)) urxe_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_serial_i(line),
        .irq_o(irq_o));
    urxe_tx_model #(.BIT_CLKS(16)) urxe_tx_model_inst (.clk_i(clk_i), .send_i(send),
        .char_i(tx_char), .par_i(tx_par), .line_o(line), .busy_o(busy));

    task automatic finish_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100)
            chk(32'hDEAD_0000, 32'h0000_0000);
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_rw(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb_rw(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask

    // Parity sense follows odd; bad flips the parity bit
    task automatic tx(input logic [7:0] c, input logic bad);
        int n;
        @(posedge clk_i);
        send    <= 1'b1;
        tx_char <= c;
        tx_par  <= (^c) ^ bad ^ odd;
        @(posedge clk_i);
        send <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (busy && n < 400);
        repeat (4) @(posedge clk_i);
    endtask

    initial
    begin
        #200_000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(URXE_OFS_LSR, 32'h0000_0000);
        rd(URXE_OFS_CTRL, 32'h0000_0000);
        rd(URXE_OFS_MASK, 32'h0000_0000);
        rd(URXE_OFS_IST, 32'h0000_0000);
        rd(URXE_OFS_DIV, 32'h0000_0035);
        rd(8'h18, 32'h0000_0000);
        wr(8'h18, 32'h0000_00FF);
        wr(URXE_OFS_DIV, 32'h0000_0000);
        wr(URXE_OFS_CTRL, 32'h0000_0006);
        wr(URXE_OFS_MASK, 32'h0000_0001);
        // Unmasked char event raises the level output
        tx(8'h3C, 1'b0);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rd(URXE_OFS_LSR, 32'h0000_0001);
        rd(URXE_OFS_IST, 32'h0000_0001);
        @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0000);
        rd(URXE_OFS_DATA, 32'h0000_003C);
        rd(URXE_OFS_LSR, 32'h0000_0000);
        wr(URXE_OFS_MASK, 32'h0000_0002);
        tx(8'hA5, 1'b1);
        chk({31'h0, irq_o}, 32'h0000_0000);
        rd(URXE_OFS_LSR, 32'h0000_0005);
        rd(URXE_OFS_LSR, 32'h0000_0001);
        // Two unread arrivals: bad then good overwrite the holding register
        tx(8'h77, 1'b1);
        tx(8'h5A, 1'b0);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rd(URXE_OFS_LSR, 32'h0000_0003);
        rd(URXE_OFS_LSR, 32'h0000_0001);
        rd(URXE_OFS_DATA, 32'h0000_005A);
        rd(URXE_OFS_IST, 32'h0000_0007);
        // Odd sense, then parity off with a bit that even sense would refuse
        wr(URXE_OFS_CTRL, 32'h0000_0004);
        odd = 1'b1;
        tx(8'hC3, 1'b0);
        rd(URXE_OFS_LSR, 32'h0000_0001);
        rd(URXE_OFS_DATA, 32'h0000_00C3);
        tx(8'h81, 1'b1);
        rd(URXE_OFS_LSR, 32'h0000_0005);
        rd(URXE_OFS_DATA, 32'h0000_0081);
        odd = 1'b0;
        wr(URXE_OFS_CTRL, 32'h0000_0002);
        tx(8'hF0, 1'b1);
        rd(URXE_OFS_LSR, 32'h0000_0001);
        rd(URXE_OFS_DATA, 32'h0000_00F0);
        // FIFO mode, depth 4, second entry carries a bad tag
        wr(URXE_OFS_CTRL, 32'h0000_0007);
        rd(URXE_OFS_LSR, 32'h0000_0000);
        tx(8'h11, 1'b0);
        tx(8'h22, 1'b1);
        tx(8'h33, 1'b0);
        tx(8'h44, 1'b0);
        rd(URXE_OFS_LSR, 32'h0000_0001);
        tx(8'h55, 1'b0);
        rd(URXE_OFS_LSR, 32'h0000_0003);
        rd(URXE_OFS_DATA, 32'h0000_0011);
        rd(URXE_OFS_LSR, 32'h0000_0005);
        rd(URXE_OFS_DATA, 32'h0000_0122);
        rd(URXE_OFS_DATA, 32'h0000_0033);
        rd(URXE_OFS_DATA, 32'h0000_0044);
        rd(URXE_OFS_LSR, 32'h0000_0000);
        finish_test();
    end
endmodule // tb_uart_rx_error_status
`default_nettype wire
